// ### logic/msu_baud_gen.sv
// Baud tick source: prescaler (f1, f8, f2n) or external clock edges,
// then the divide-by-(m+1) counter; emits 16 ticks per bit.
// Assumes ext_clock_pin is synchronous to pclk.
`timescale 1ns/10ps
module msu_baud_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] count_source_sel,
  input wire logic [3:0] prescale_div_field,
  input wire logic clock_source_sel,
  input wire logic ext_clock_pin,
  input wire logic [7:0] baud_divisor,
  output logic tick16
);
  import msu_pkg::*;

  logic [4:0] pre_cnt_r;
  logic [4:0] pre_lim;
  logic pre_en;
  logic ext_d_r;
  logic src_en;
  logic [7:0] div_cnt_r;

  // Prescaler limit; n=0 of f2n means no division
  always_comb begin
    case (count_source_sel)
      CS_F8: pre_lim = F8_LIMIT; // [RL10]
      CS_F2N: pre_lim = (prescale_div_field == 4'h0) ? 5'h00 :
                        5'({prescale_div_field, 1'b0} - 5'h01); // [RL10]
      default: pre_lim = 5'h00;
    endcase
  end

  assign pre_en = (pre_cnt_r >= pre_lim);

  // Prescaler counter; >= guards a limit lowered mid-count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 5'h00;
    end else if (pre_en) begin
      pre_cnt_r <= 5'h00;
    end else begin
      pre_cnt_r <= 5'(pre_cnt_r + 5'h01);
    end
  end

  // Rising edges of the external clock act as the count source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_clock_pin;
    end
  end

  assign src_en = clock_source_sel ? (ext_clock_pin & ~ext_d_r) : pre_en; // [RL9]

  // Divide by divisor plus one; 16 of these ticks make one bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 8'h00;
      tick16 <= 1'b0;
    end else begin
      tick16 <= 1'b0;
      if (src_en) begin
        if (div_cnt_r >= baud_divisor) begin
          div_cnt_r <= 8'h00;
          tick16 <= 1'b1; // [RL8] [RL9]
        end else begin
          div_cnt_r <= 8'(div_cnt_r + 8'h01);
        end
      end
    end
  end

endmodule

// ### logic/msu_pkg.sv
// Shared constants for the serial channel: register map, field layout,
// state encodings and character-length decoding.
// Assumes a 32-bit APB slave with word-aligned registers.
package msu_pkg;

  // APB byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_TXBUF = 8'h00;
  localparam logic [7:0] OFS_RXBUF = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0C;
  localparam logic [7:0] OFS_CTRL0 = 8'h10;
  localparam logic [7:0] OFS_CTRL1 = 8'h14;
  localparam logic [7:0] OFS_SPM1 = 8'h18;
  localparam logic [7:0] OFS_SPM2 = 8'h1C;
  localparam logic [7:0] OFS_SPM3 = 8'h20;
  localparam logic [7:0] OFS_SPM4 = 8'h24;
  localparam logic [7:0] OFS_PRESC = 8'h28;

  // serial_mode_reg fields
  localparam int MR_CLK_SRC = 3;
  localparam int MR_STOP2 = 4;
  localparam int MR_PAR_EVEN = 5;
  localparam int MR_PAR_EN = 6;
  localparam int MR_POL_INV = 7;
  localparam logic [2:0] MODE_CSYNC = 3'h1;
  localparam logic [2:0] MODE_UART7 = 3'h4;
  localparam logic [2:0] MODE_UART8 = 3'h5;
  localparam logic [2:0] MODE_UART9 = 3'h6;

  // line_control0_reg fields
  localparam int C0_FLOW_RTS = 2;
  localparam int C0_SHIFT_EMPTY = 3;
  localparam int C0_FLOW_DIS = 4;
  localparam int C0_OPEN_DRAIN = 5;
  localparam int C0_MSB_FIRST = 7;

  // line_control1_reg fields
  localparam int C1_TX_EN = 0;
  localparam int C1_TX_EMPTY = 1;
  localparam int C1_RX_EN = 2;
  localparam int C1_RX_DONE = 3;
  localparam int C1_TX_IRQ_SEL = 4;
  localparam int C1_CONT_RX = 5;
  localparam int C1_DATA_INV = 6;

  // rx_holding_buffer_reg error field positions
  localparam int RB_OVR = 12;
  localparam int RB_FRM = 13;
  localparam int RB_PAR = 14;
  localparam int RB_SUM = 15;

  // Count source codes and bit timing
  localparam logic [1:0] CS_F1 = 2'h0;
  localparam logic [1:0] CS_F8 = 2'h1;
  localparam logic [1:0] CS_F2N = 2'h2;
  localparam logic [4:0] F8_LIMIT = 5'h07;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [3:0] LEN_7 = 4'h7;
  localparam logic [3:0] LEN_8 = 4'h8;
  localparam logic [3:0] LEN_9 = 4'h9;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
    TX_PAR = 5'b01000, TX_STOP = 5'b10000
  } msu_tx_state_t;

  typedef enum logic [5:0] {
    RX_IDLE = 6'b000001, RX_START = 6'b000010, RX_DATA = 6'b000100,
    RX_PAR = 6'b001000, RX_STOP1 = 6'b010000, RX_STOP2 = 6'b100000
  } msu_rx_state_t;

  // Character length from the mode field; zero when not an async mode
  function automatic logic [3:0] msu_char_len(input logic [2:0] mode);
    case (mode)
      MODE_UART7: msu_char_len = LEN_7;
      MODE_UART8: msu_char_len = LEN_8;
      MODE_UART9: msu_char_len = LEN_9;
      default: msu_char_len = 4'h0;
    endcase
  endfunction

endpackage

// ### logic/msu_uart.sv
// Asynchronous serial channel with APB register access.
// Assumes pins are synchronous to pclk and APB follows the usual handshake.
// Notes on behaviour
// RL1 - In clock-sync mode with continuous receive, reading rx buffer marks tx buffer full.
// RL2 - Software writes no dummy tx data while continuous receive is on.
// RL3 - Data inversion complements transmitted data bits and received data read back.
// RL4 - Characters carry 7, 8 or 9 data bits after one start bit.
// RL5 - One or two stop bits follow each character, per stop-length setting.
// RL6 - Parity is odd, even or absent per parity enable and type.
// RL7 - Mode field 100, 101, 110 selects 7, 8, 9-bit async characters.
// RL8 - Internal clock: bit rate is prescaled clock over 16 times divisor plus one.
// RL9 - External clock: bit rate is pin frequency over 16 times divisor plus one.
// RL10 - Prescaler field: zero means no division, else divide by 2n.
// RL11 - Transmit starts with tx enabled, data buffered and, if selected, clear-to-send low.
// RL12 - Reception starts only when enabled and a start bit is seen.
// RL13 - Tx interrupt on buffer load when select is 0, on completion when 1.
// RL14 - Rx interrupt when a finished character reaches the holding buffer.
// RL15 - Overrun if buffer unread when the bit before the last stop bit arrives.
// RL16 - On overrun the buffer is undefined and no rx interrupt is raised.
// RL17 - Framing error when the configured stop bits are not found.
// RL18 - Parity error on mismatch; summary flag on any overrun, framing or parity error.
// RL19 - Data inversion leaves start and stop bits alone; keep off for 9-bit.
// RL20 - Line polarity inversion flips the entire tx output and rx input.
// RL21 - Bit order selection applies to 8-bit characters only.
// RL22 - Buffers use the low 7, 8 or 9 bits; tx idles high or released.
// RL23 - Start bit qualified at its middle; bits sampled mid-period.
`timescale 1ns/10ps
module msu_uart (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [msu_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  input wire logic clear_to_send_pin,
  input wire logic ext_clock_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic req_to_send_n,
  output logic tx_irq_req,
  output logic rx_irq_req
);
  import msu_pkg::*;

  logic [8:0] tb_r;
  logic [8:0] rb_r;
  logic [7:0] brg_r;
  logic [7:0] mr_r;
  logic [7:0] c0_r;
  logic [7:0] c1_r;
  logic [7:0] spm1_r;
  logic [7:0] spm2_r;
  logic [7:0] spm3_r;
  logic [7:0] spm4_r;
  logic [3:0] presc_r;
  logic tx_empty_r;
  logic shift_empty_r;
  logic rx_done_r;
  logic ovr_r;
  logic frm_r;
  logic par_r;
  logic tick;
  logic [3:0] char_len;
  logic uart_on;
  logic fmt_inv;
  logic fmt_msb;
  logic acc_done;
  logic wr_en;
  logic rd_en;
  logic tx_wr;
  logic rb_rd;
  logic [31:0] rd_mux;
  logic rd_hit;
  msu_tx_state_t tx_st_r;
  logic [8:0] tx_sh_r;
  logic tx_par_r;
  logic [3:0] tx_cnt_r;
  logic [3:0] tx_bit_r;
  logic tx_line;
  logic cts_ok;
  logic tx_start;
  logic tx_finish;
  msu_rx_state_t rx_st_r;
  logic [8:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic rx_bad_stop_r;
  logic rx_par_bit_r;
  logic rx_ovr_mark_r;
  logic rx_line;
  logic rx_mid;
  logic rx_finish;
  logic rx_to_last_stop;
  logic [8:0] rx_data;
  logic rx_par_err;

  // Mask to length, complement (not for 9-bit), reverse for 8-bit MSB-first
  function automatic logic [8:0] fmt_data(input logic [8:0] d, input logic [3:0] len,
                                          input logic inv, input logic msb);
    logic [8:0] r;
    r = d;
    if (len == LEN_7) begin
      r[8:7] = 2'h0;
    end else if (len == LEN_8) begin
      r[8] = 1'b0;
    end
    if (inv && len != LEN_9) begin
      r = r ^ ((len == LEN_7) ? 9'h07F : 9'h0FF); // [RL3] [RL19]
    end
    if (msb && len == LEN_8) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7 - i] ^ (inv ? 1'b1 : 1'b0); // [RL21]
      end
    end
    fmt_data = r;
  endfunction

  assign char_len = msu_char_len(mr_r[2:0]); // [RL7]
  assign uart_on = (char_len != 4'h0);
  assign fmt_inv = c1_r[C1_DATA_INV];
  assign fmt_msb = c0_r[C0_MSB_FIRST];

  msu_baud_gen u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .count_source_sel(c0_r[1:0]),
    .prescale_div_field(presc_r),
    .clock_source_sel(mr_r[MR_CLK_SRC]),
    .ext_clock_pin(ext_clock_pin),
    .baud_divisor(brg_r),
    .tick16(tick)
  );

  // APB: one wait state so read data can come from a flop
  assign acc_done = psel & penable & pready;
  assign wr_en = acc_done & pwrite & ~pslverr;
  assign rd_en = acc_done & ~pwrite & ~pslverr;
  assign tx_wr = wr_en && paddr == OFS_TXBUF;
  assign rb_rd = rd_en && paddr == OFS_RXBUF;

  // Read mux; error summary is derived, never stored
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      OFS_TXBUF: rd_mux = 32'h0000_0000;
      OFS_RXBUF: begin
        rd_mux[8:0] = rb_r;
        rd_mux[RB_OVR] = ovr_r;
        rd_mux[RB_FRM] = frm_r;
        rd_mux[RB_PAR] = par_r;
        rd_mux[RB_SUM] = ovr_r | frm_r | par_r; // [RL18]
      end
      OFS_BAUD: rd_mux = 32'h0000_0000;
      OFS_MODE: rd_mux[7:0] = mr_r;
      OFS_CTRL0: begin
        rd_mux[7:0] = c0_r;
        rd_mux[C0_SHIFT_EMPTY] = shift_empty_r;
      end
      OFS_CTRL1: begin
        rd_mux[7:0] = c1_r;
        rd_mux[C1_TX_EMPTY] = tx_empty_r;
        rd_mux[C1_RX_DONE] = rx_done_r;
      end
      OFS_SPM1: rd_mux[7:0] = spm1_r;
      OFS_SPM2: rd_mux[7:0] = spm2_r;
      OFS_SPM3: rd_mux[7:0] = spm3_r;
      OFS_SPM4: rd_mux[7:0] = spm4_r;
      OFS_PRESC: rd_mux[3:0] = presc_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // Answer flops: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~rd_hit;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Software-written registers; status bits in them are read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_r <= 9'h000;
      brg_r <= 8'h00;
      mr_r <= 8'h00;
      c0_r <= 8'h00;
      c1_r <= 8'h00;
      spm1_r <= 8'h00;
      spm2_r <= 8'h00;
      spm3_r <= 8'h00;
      spm4_r <= 8'h00;
      presc_r <= 4'h0;
    end else if (wr_en) begin
      case (paddr)
        OFS_TXBUF: tb_r <= pwdata[8:0]; // [RL22]
        OFS_BAUD: brg_r <= pwdata[7:0];
        OFS_MODE: mr_r <= pwdata[7:0];
        OFS_CTRL0: c0_r <= pwdata[7:0];
        OFS_CTRL1: c1_r <= pwdata[7:0];
        OFS_SPM1: spm1_r <= pwdata[7:0];
        OFS_SPM2: spm2_r <= pwdata[7:0];
        OFS_SPM3: spm3_r <= pwdata[7:0];
        OFS_SPM4: spm4_r <= pwdata[7:0];
        OFS_PRESC: presc_r <= pwdata[3:0];
        default: presc_r <= presc_r;
      endcase
    end
  end

  // Transmit start; a buffer write in the same cycle defers the load
  assign cts_ok = c0_r[C0_FLOW_DIS] | c0_r[C0_FLOW_RTS] | ~clear_to_send_pin; // [RL11]
  assign tx_start = uart_on & c1_r[C1_TX_EN] & ~tx_empty_r & cts_ok & ~tx_wr &
                    (tx_st_r == TX_IDLE); // [RL11]
  assign tx_finish = tick && tx_cnt_r == TICK_LAST && tx_st_r == TX_STOP &&
                     (tx_bit_r != 4'h0 || !mr_r[MR_STOP2]);

  // Transmit sequencer: 16 ticks per bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 9'h000;
      tx_par_r <= 1'b0;
      tx_cnt_r <= 4'h0;
      tx_bit_r <= 4'h0;
    end else if (tx_start) begin
      tx_st_r <= TX_START; // [RL4]
      tx_sh_r <= fmt_data(tb_r, char_len, fmt_inv, fmt_msb); // [RL3] [RL21]
      tx_par_r <= ^fmt_data(tb_r, char_len, fmt_inv, fmt_msb) ^ ~mr_r[MR_PAR_EVEN]; // [RL6]
      tx_cnt_r <= 4'h0;
      tx_bit_r <= 4'h0;
    end else if (tick && tx_st_r != TX_IDLE) begin
      tx_cnt_r <= 4'(tx_cnt_r + 4'h1);
      if (tx_cnt_r == TICK_LAST) begin
        tx_bit_r <= 4'(tx_bit_r + 4'h1);
        case (tx_st_r)
          TX_START: begin
            tx_st_r <= TX_DATA;
            tx_bit_r <= 4'h0;
          end
          TX_DATA: begin
            if (tx_bit_r == 4'(char_len - 4'h1)) begin
              tx_st_r <= mr_r[MR_PAR_EN] ? TX_PAR : TX_STOP; // [RL6]
              tx_bit_r <= 4'h0;
            end
          end
          TX_PAR: begin
            tx_st_r <= TX_STOP;
            tx_bit_r <= 4'h0;
          end
          TX_STOP: begin
            if (tx_finish) begin
              tx_st_r <= TX_IDLE; // [RL5]
            end
          end
          default: tx_st_r <= TX_IDLE;
        endcase
      end
    end
  end

  // Line level before polarity; start and stop are never data-inverted
  always_comb begin
    case (tx_st_r)
      TX_START: tx_line = 1'b0;
      TX_DATA: tx_line = tx_sh_r[tx_bit_r];
      TX_PAR: tx_line = tx_par_r;
      default: tx_line = 1'b1; // [RL22]
    endcase
  end

  // Pin drive; open-drain releases the pin for a high level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin <= 1'b1;
      serial_out_oe <= 1'b1;
    end else begin
      serial_out_pin <= tx_line ^ mr_r[MR_POL_INV]; // [RL20]
      serial_out_oe <= ~c0_r[C0_OPEN_DRAIN] | ~(tx_line ^ mr_r[MR_POL_INV]); // [RL22]
    end
  end

  // Transmit flags; hardware set beats software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_r <= 1'b1;
      shift_empty_r <= 1'b1;
      tx_irq_req <= 1'b0;
    end else begin
      tx_irq_req <= (tx_start & ~c1_r[C1_TX_IRQ_SEL]) |
                    (tx_finish & c1_r[C1_TX_IRQ_SEL]); // [RL13]
      if (tx_start) begin
        tx_empty_r <= 1'b1;
      end else if (tx_wr) begin
        tx_empty_r <= 1'b0;
      end else if (rb_rd && c1_r[C1_CONT_RX] && mr_r[2:0] == MODE_CSYNC) begin
        tx_empty_r <= 1'b0; // [RL1]
      end
      if (tx_start) begin
        shift_empty_r <= 1'b0;
      end else if (tx_finish) begin
        shift_empty_r <= 1'b1;
      end
    end
  end

  // Receive sampling helpers
  assign rx_line = serial_in_pin ^ mr_r[MR_POL_INV]; // [RL20]
  assign rx_mid = tick && rx_cnt_r == TICK_LAST;
  assign rx_finish = rx_mid && (rx_st_r == RX_STOP2 ||
                     (rx_st_r == RX_STOP1 && !mr_r[MR_STOP2]));
  assign rx_to_last_stop = rx_mid && ((rx_st_r == RX_STOP1 && mr_r[MR_STOP2]) ||
                           (!mr_r[MR_STOP2] && (rx_st_r == RX_PAR ||
                           (rx_st_r == RX_DATA && !mr_r[MR_PAR_EN] &&
                            rx_bit_r == 4'(char_len - 4'h1)))));
  assign rx_data = fmt_data(rx_sh_r, char_len, fmt_inv, fmt_msb); // [RL3] [RL21]
  assign rx_par_err = mr_r[MR_PAR_EN] &
                      (^rx_sh_r ^ rx_par_bit_r ^ ~mr_r[MR_PAR_EVEN]); // [RL18]

  // Receive sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= RX_IDLE;
      rx_sh_r <= 9'h000;
      rx_cnt_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_bad_stop_r <= 1'b0;
      rx_par_bit_r <= 1'b0;
      rx_ovr_mark_r <= 1'b0;
    end else if (!c1_r[C1_RX_EN] || !uart_on) begin
      rx_st_r <= RX_IDLE;
    end else if (tick) begin
      rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
      if (rx_to_last_stop) begin
        rx_ovr_mark_r <= rx_done_r; // [RL15]
      end
      case (rx_st_r)
        RX_IDLE: begin
          rx_cnt_r <= 4'h0;
          if (!rx_line) begin
            rx_st_r <= RX_START; // [RL12]
          end
        end
        RX_START: begin
          if (rx_cnt_r == TICK_HALF) begin
            rx_cnt_r <= 4'h0;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 9'h000;
            rx_bad_stop_r <= 1'b0;
            rx_st_r <= rx_line ? RX_IDLE : RX_DATA; // [RL23]
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_sh_r[rx_bit_r] <= rx_line; // [RL4] [RL23]
            rx_bit_r <= 4'(rx_bit_r + 4'h1);
            if (rx_bit_r == 4'(char_len - 4'h1)) begin
              rx_st_r <= mr_r[MR_PAR_EN] ? RX_PAR : RX_STOP1;
            end
          end
        end
        RX_PAR: begin
          if (rx_mid) begin
            rx_par_bit_r <= rx_line;
            rx_st_r <= RX_STOP1;
          end
        end
        RX_STOP1: begin
          if (rx_mid) begin
            rx_bad_stop_r <= ~rx_line;
            rx_st_r <= mr_r[MR_STOP2] ? RX_STOP2 : RX_IDLE; // [RL5]
          end
        end
        RX_STOP2: begin
          if (rx_mid) begin
            rx_bad_stop_r <= rx_bad_stop_r | ~rx_line;
            rx_st_r <= RX_IDLE;
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // Holding buffer, completion flag and errors; set wins over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_r <= 9'h000;
      rx_done_r <= 1'b0;
      ovr_r <= 1'b0;
      frm_r <= 1'b0;
      par_r <= 1'b0;
      rx_irq_req <= 1'b0;
    end else begin
      rx_irq_req <= 1'b0;
      if (rx_finish) begin
        rb_r <= rx_data; // [RL22]
        frm_r <= rx_bad_stop_r | ~rx_line; // [RL17]
        par_r <= rx_par_err; // [RL18]
        if (rx_ovr_mark_r) begin
          ovr_r <= 1'b1; // [RL15] [RL16]
        end else begin
          rx_done_r <= 1'b1;
          rx_irq_req <= 1'b1; // [RL14]
        end
      end else begin
        if (rb_rd) begin
          rx_done_r <= 1'b0;
        end
        if (!c1_r[C1_RX_EN]) begin
          ovr_r <= 1'b0;
        end
      end
    end
  end

  // Request-to-send asks for data while the holding buffer is free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_to_send_n <= 1'b1;
    end else begin
      req_to_send_n <= ~(c0_r[C0_FLOW_RTS] & ~c0_r[C0_FLOW_DIS] &
                         c1_r[C1_RX_EN] & ~rx_done_r);
    end
  end

endmodule

// ### testbench/msu_line_model.sv
// Remote serial device: sends frames to the channel and samples its output.
// Assumes bit periods are whole pclk cycles, given per call.
`timescale 1ns/10ps
module msu_line_model (
  input wire logic pclk,
  input wire logic line_from_dut,
  output logic line_to_dut
);
  initial line_to_dut = 1'b1;
  // Levels go out LSB first; the line rests high as if pulled up
  task automatic send(input logic [12:0] lv, input int n, input int parity_error_flag);
    for (int i = 0; i < n; i++) begin
      line_to_dut <= lv[i];
      repeat (parity_error_flag) @(posedge pclk);
    end
    line_to_dut <= 1'b1;
  endtask
  // Sampling on the falling edge keeps clear of the output's update
  task automatic grab(input int n, input int parity_error_flag, output logic [12:0] lv);
    int k;
    lv = '1;
    k = 0;
    while (line_from_dut !== 1'b0 && k < 4000) begin
      @(negedge pclk);
      k++;
    end
    repeat (parity_error_flag / 2) @(negedge pclk);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (parity_error_flag) @(negedge pclk);
      lv[i] = line_from_dut;
    end
  endtask
endmodule

// ### testbench/msu_uart_asserts.sv
// Checker for the APB handshake and serial pin timing of msu_uart.
// Sees only the top module's ports; the bind follows the module.
`timescale 1ns/10ps
module msu_uart_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [msu_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_in_pin,
  input wire logic clear_to_send_pin,
  input wire logic ext_clock_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic req_to_send_n,
  input wire logic tx_irq_req,
  input wire logic rx_irq_req
);
  import msu_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // First edge of an access phase
  sequence s_access;
    psel && penable && !$past(penable);
  endsequence
  // One wait state, then a single-cycle answer
  sequence s_answer;
    !pready ##1 pready ##1 !pready;
  endsequence
  chk_ready_wait: assert property (s_access |-> s_answer)
    else $error("pready not on second access edge");
  chk_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answer");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero between answers");
  // Fastest bit is sixteen cycles; each level must last at least nine
  chk_bit_hold: assert property (
    $changed(serial_out_pin) |=> $stable(serial_out_pin) [*8])
    else $error("serial_out_pin level too short");
  chk_txirq_pulse: assert property (tx_irq_req |=> !tx_irq_req)
    else $error("tx_irq_req longer than one cycle");
  chk_rxirq_gap: assert property (rx_irq_req |=> !rx_irq_req [*8])
    else $error("rx_irq_req repeated too soon");
  chk_oe_low: assert property (!serial_out_pin |-> serial_out_oe)
    else $error("low level not driven");
  chk_ready_hold: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready without an access");
endmodule

bind msu_uart msu_uart_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_in_pin, .clear_to_send_pin,
  .ext_clock_pin, .serial_out_pin, .serial_out_oe, .req_to_send_n, .tx_irq_req,
  .rx_irq_req);

// ### testbench/msu_uart_tb.sv
// Self-checking bench for msu_uart: APB tasks, tx and rx characters.
// Assumes the line model below and a 50 ns pclk.
`timescale 1ns/10ps
module msu_uart_tb;
  import msu_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cts = 1'b1, ext = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, rerr, sin, sout, soe, rts_n, txi, rxi;
  logic [12:0] lv;
  int fails = 0, n_compared = 0, txc = 0, rxc = 0, n0, len;
  logic [31:0] t_mode [7] = '{32'h05, 32'h74, 32'h05, 32'h46, 32'h05, 32'h0D, 32'h05};
  logic [31:0] t_c0 [7] = '{32'h0, 32'h0, 32'h01, 32'h0, 32'h80, 32'h0, 32'h02};
  logic [31:0] t_c1 [7] = '{32'h05, 32'h05, 32'h45, 32'h15, 32'h05, 32'h05, 32'h05};
  logic [31:0] t_baud [7] = '{32'h0, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] t_dat [7] = '{32'hA5, 32'h55, 32'h3C, 32'h1A5, 32'hB1, 32'h6E, 32'h96};
  logic [8:0] t_line [7] = '{9'hA5, 9'h55, 9'hC3, 9'h1A5, 9'h8D, 9'h6E, 9'h96};
  int t_per [7] = '{16, 48, 128, 16, 16, 32, 32};
  always #25 pclk = ~pclk;
  // External count source: one rising edge every second pclk
  always @(posedge pclk) ext <= ~ext;
  // Interrupt pulses are counted, not sampled by the tests
  always @(posedge pclk) begin
    if (txi === 1'b1) txc <= txc + 1;
    if (rxi === 1'b1) rxc <= rxc + 1;
  end
  msu_uart DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .serial_in_pin(sin), .clear_to_send_pin(cts),
    .ext_clock_pin(ext), .serial_out_pin(sout), .serial_out_oe(soe),
    .req_to_send_n(rts_n), .tx_irq_req(txi), .rx_irq_req(rxi));
  msu_line_model u_far (.pclk, .line_from_dut(sout), .line_to_dut(sin));
  task automatic complete_run;
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Answer taken at the rising edge where pready is seen; one idle edge after
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Line levels from start bit on; stop bits stay at the default high
  function automatic logic [12:0] frame(input int len, input logic [8:0] d,
                                        input logic pe, input logic ev);
    frame = '1;
    frame[0] = 1'b0;
    for (int i = 0; i < len; i++) frame[i+1] = d[i];
    if (pe) frame[len+1] = ev ? ^d : ~^d;
  endfunction
  task automatic rx_one(input logic [8:0] d, input logic pe, input logic [12:0] flip);
    u_far.send(frame(8, d, pe, 1'b0) ^ flip, 10 + pe, 16);
    repeat (20) @(posedge pclk);
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    fails++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFS_CTRL1, 0);
    chk(rdat, 32'h02);
    apb(0, OFS_CTRL0, 0);
    chk(rdat, 32'h08);
    chk({31'h0, sout}, 32'h1);
    apb(0, 8'h3C, 0);
    chk({rerr, rdat[30:0]}, 32'h80000000);
    apb(1, OFS_CTRL0, 32'h20);
    repeat (2) @(posedge pclk);
    chk({31'h0, soe}, 32'h0);
    apb(1, OFS_PRESC, 32'h1);
    // Each character: format, rate, inversion, order and irq timing
    for (int c = 0; c < 7; c++) begin
      apb(1, OFS_BAUD, t_baud[c]);
      apb(1, OFS_MODE, t_mode[c]);
      apb(1, OFS_CTRL0, t_c0[c]);
      apb(1, OFS_CTRL1, t_c1[c]);
      n0 = txc;
      apb(1, OFS_TXBUF, t_dat[c]);
      if (c == 0) begin
        repeat (40) @(negedge pclk);
        chk({31'h0, sout}, 32'h1);
        @(posedge pclk);
        cts <= 1'b0;
      end
      len = int'(t_mode[c][2:0]) + 3;
      u_far.grab(len + 2 + t_mode[c][6] + t_mode[c][4], t_per[c], lv);
      chk({19'h0, lv}, {19'h0, frame(len, t_line[c], t_mode[c][6], t_mode[c][5])});
      chk(32'(txc - n0), {31'h0, ~t_c1[c][4]});
      repeat (t_per[c]) @(posedge pclk);
      chk(32'(txc - n0), 32'h1);
    end
    apb(1, OFS_CTRL0, 32'h04);
    n0 = rxc;
    rx_one(9'h05A, 0, 0);
    chk(32'(rxc - n0), 32'h1);
    chk({31'h0, rts_n}, 32'h1);
    apb(0, OFS_RXBUF, 0);
    chk(rdat, 32'h05A);
    apb(1, OFS_CTRL1, 32'h45);
    chk({31'h0, rts_n}, 32'h0);
    rx_one(9'h00F, 0, 0);
    apb(0, OFS_RXBUF, 0);
    chk(rdat, 32'h0F0);
    apb(1, OFS_CTRL1, 32'h05);
    rx_one(9'h011, 0, 0);
    rx_one(9'h022, 0, 0);
    apb(0, OFS_RXBUF, 0);
    chk(rdat & 32'h9000, 32'h9000);
    chk(32'(rxc - n0), 32'h3);
    apb(1, OFS_CTRL1, 32'h01);
    rx_one(9'h033, 0, 0);
    chk(32'(rxc - n0), 32'h3);
    apb(1, OFS_CTRL1, 32'h05);
    apb(1, OFS_MODE, 32'h65);
    rx_one(9'h001, 1, 0);
    apb(0, OFS_RXBUF, 0);
    chk(rdat & 32'hF000, 32'hC000);
    apb(1, OFS_MODE, 32'h05);
    rx_one(9'h044, 0, 13'h200);
    apb(0, OFS_RXBUF, 0);
    chk(rdat & 32'hF000, 32'hA000);
    // Continuous receive: the read alone refills, no dummy write
    apb(1, OFS_MODE, 32'h81);
    apb(1, OFS_CTRL1, 32'h20);
    apb(0, OFS_RXBUF, 0);
    apb(0, OFS_CTRL1, 0);
    chk(rdat & 32'h02, 32'h0);
    chk({31'h0, sout}, 32'h0);
    complete_run();
  end
endmodule
